// File: rtl/iss_cfg.svh
// offsets, field positions, reset values and step counts
`ifndef ISS_CFG_SVH
`define ISS_CFG_SVH
`define ISS_ADDR_W 8
`define ISS_OFF_CTRL 8'h00
`define ISS_OFF_STAT 8'h04
`define ISS_OFF_OPA 8'h08
`define ISS_OFF_OPB 8'h0C
`define ISS_OFF_CMD 8'h10
`define ISS_OFF_RES 8'h14
`define ISS_OFF_EPC 8'h18
`define ISS_CTRL_ISA 0
`define ISS_CTRL_USER 1
`define ISS_CTRL_FLIP 2
`define ISS_CTRL_COC 3
`define ISS_CTRL_CSS 4
`define ISS_STAT_MEMBE 0
`define ISS_STAT_LSBE 1
`define ISS_STAT_SWAP 2
`define ISS_STAT_LL 3
`define ISS_STAT_BRP 4
`define ISS_STAT_BUSY 5
`define ISS_STAT_FCC0 6
`define ISS_CMD_OP 0
`define ISS_CMD_RD 8
`define ISS_CMD_RS 16
`define ISS_CMD_RT 24
`define ISS_CMD_IS16 31
`define ISS_PC_RESET 32'h0000_1000
`define ISS_EXC_VECTOR 32'h0000_2000
`define ISS_STEP16 32'h0000_0002
`define ISS_STEP32 32'h0000_0004
`endif

// File: rtl/iss_pkg.sv
// types shared by the architectural state block
package iss_pkg;
  typedef enum logic [1:0] {ISS_IDLE, ISS_RD, ISS_EX} iss_fsm_t;
  typedef enum logic [4:0] {
    ISS_NOP = 5'h00, ISS_SETR = 5'h01, ISS_GETR = 5'h02, ISS_ADD = 5'h03,
    ISS_SUB = 5'h04, ISS_SLT = 5'h05, ISS_SLL = 5'h06, ISS_SRL = 5'h07,
    ISS_MUL = 5'h08, ISS_DIV = 5'h09, ISS_MOD = 5'h0A, ISS_EXT = 5'h0B,
    ISS_LDB = 5'h0C, ISS_LL = 5'h0D, ISS_SC = 5'h0E, ISS_ST = 5'h0F,
    ISS_BR = 5'h10, ISS_BAL = 5'h11, ISS_EXC = 5'h12, ISS_ERET = 5'h13,
    ISS_ADDPC = 5'h14
  } iss_op_t;
  typedef struct packed {
    logic strap_s1;
    logic strap_s2;
    logic mem_be;
    logic isa_sel;
    logic user_mode;
    logic flip_bit;
    logic coc1;
    logic [3:0] current_shadow_set;
    logic [31:0] opa;
    logic [31:0] opb;
    iss_op_t op;
    logic [4:0] rd;
    logic [4:0] rs;
    logic [4:0] rt;
    logic is16;
    iss_fsm_t fsm;
    logic [31:0] pc;
    logic [31:0] epc;
    logic [31:0] br_tgt;
    logic [31:0] ll_addr;
    logic [31:0] result;
    logic [31:0] prdata;
    logic br_pend;
    logic ll_flag;
    logic pready;
    logic pslverr;
    logic swap_o;
    logic lsbe_o;
    logic fcc_o;
  } iss_state_t;
endpackage

// File: rtl/iss_gpr_if.sv
// register file port bundle between core and storage
`timescale 1ns/100ps
`default_nettype none
interface iss_gpr_if #(parameter int W = 32, parameter int SW = 1);
  logic re;
  logic [SW-1:0] rset;
  logic [4:0] ra;
  logic [4:0] rb;
  logic [W-1:0] qa;
  logic [W-1:0] qb;
  logic we;
  logic [SW-1:0] wset;
  logic [4:0] wa;
  logic [W-1:0] wd;
  modport core (output re, rset, ra, rb, we, wset, wa, wd, input qa, qb);
  modport mem (input re, rset, ra, rb, we, wset, wa, wd, output qa, qb);
endinterface
`default_nettype wire

// File: rtl/iss_gpr_mem.sv
// banked general-purpose register storage, registered reads
`timescale 1ns/100ps
`default_nettype none
module iss_gpr_mem #(
  parameter int W = 32,
  parameter int SW = 1
) (
  input wire logic sys_clk,
  iss_gpr_if.mem gif
);
  logic [W-1:0] mem [(2**SW)*32];
  logic [W-1:0] qa_q;
  logic [W-1:0] qb_q;

  always_ff @(posedge sys_clk) begin
    if (gif.re) begin
      // register zero never leaves storage as anything but zero
      qa_q <= (gif.ra == 5'h00) ? '0 : mem[{gif.rset, gif.ra}];
      qb_q <= (gif.rb == 5'h00) ? '0 : mem[{gif.rset, gif.rb}];
    end
    if (gif.we && gif.wa != 5'h00) begin
      mem[{gif.wset, gif.wa}] <= gif.wd;
    end
  end

  assign gif.qa = qa_q;
  assign gif.qb = qb_q;
endmodule // iss_gpr_mem
`default_nettype wire

// File: rtl/iss_state_core.sv
// architectural state core: registers, byte order, reservation, pc
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/100ps
`default_nettype none
`include "iss_cfg.svh"
module iss_state_core #(
  parameter int GP_REGISTER_WIDTH = 32,
  parameter int NUM_SETS = 2,
  parameter bit RELEASE6 = 1'b0,
  parameter logic [31:0] PC_RESET = `ISS_PC_RESET,
  parameter logic [31:0] EXC_VECTOR = `ISS_EXC_VECTOR
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ISS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic byte_order_strap,
  output logic memory_byte_order_cfg,
  output logic loadstore_byte_order,
  output logic user_byte_swap_signal,
  output logic link_reservation_flag,
  output logic instruction_set_select,
  output logic fp_condition_code0
);
  localparam int W = GP_REGISTER_WIDTH;
  localparam int SW = (NUM_SETS > 1) ? $clog2(NUM_SETS) : 1;
  localparam int SHW = $clog2(W);

  iss_pkg::iss_state_t st_q;
  iss_pkg::iss_state_t st_d;

  iss_gpr_if #(.W(W), .SW(SW)) gif ();

  iss_gpr_mem #(.W(W), .SW(SW)) u_mem (
    .sys_clk(sys_clk),
    .gif(gif.mem)
  );

  // widen a 32-bit operand to register width, two's complement
  function automatic logic [W-1:0] sext(input logic [31:0] v);
    return W'($signed(v));
  endfunction

  // byte y of a word
  function automatic logic [7:0] byte_of(input logic [31:0] v,
                                         input logic [1:0] y);
    return v[8*y +: 8];
  endfunction

  // bits hi..lo right aligned; empty, so zero, when hi is below lo
  function automatic logic [W-1:0] field_sel(input logic [W-1:0] v,
                                             input logic [4:0] hi,
                                             input logic [4:0] lo);
    logic [W-1:0] mask;
    mask = '0;
    if (hi < lo) begin
      return '0;
    end
    mask = ~('1 << (SHW'(hi) - SHW'(lo) + SHW'(1)));
    if (hi - lo == 5'h1F && W == 32) begin
      mask = '1;
    end
    return (v >> lo) & mask;
  endfunction

  // read-side decode also tells whether the address is mapped
  logic rd_hit;
  logic [31:0] rd_val;
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      `ISS_OFF_CTRL: begin
        rd_val[`ISS_CTRL_ISA] = st_q.isa_sel;
        rd_val[`ISS_CTRL_USER] = st_q.user_mode;
        rd_val[`ISS_CTRL_FLIP] = st_q.flip_bit;
        rd_val[`ISS_CTRL_COC] = st_q.coc1;
        rd_val[`ISS_CTRL_CSS +: 4] = st_q.current_shadow_set;
      end
      `ISS_OFF_STAT: begin
        rd_val[`ISS_STAT_MEMBE] = st_q.mem_be;
        rd_val[`ISS_STAT_LSBE] = st_q.lsbe_o;
        rd_val[`ISS_STAT_SWAP] = st_q.swap_o;
        rd_val[`ISS_STAT_LL] = st_q.ll_flag;
        rd_val[`ISS_STAT_BRP] = st_q.br_pend;
        rd_val[`ISS_STAT_BUSY] = (st_q.fsm != iss_pkg::ISS_IDLE);
        rd_val[`ISS_STAT_FCC0] = st_q.fcc_o;
      end
      `ISS_OFF_OPA: rd_val = st_q.opa;
      `ISS_OFF_OPB: rd_val = st_q.opb;
      `ISS_OFF_CMD: begin
        rd_val[`ISS_CMD_OP +: 5] = st_q.op;
        rd_val[`ISS_CMD_RD +: 5] = st_q.rd;
        rd_val[`ISS_CMD_RS +: 5] = st_q.rs;
        rd_val[`ISS_CMD_RT +: 5] = st_q.rt;
        rd_val[`ISS_CMD_IS16] = st_q.is16;
      end
      `ISS_OFF_RES: rd_val = st_q.result;
      `ISS_OFF_EPC: rd_val = st_q.epc;
      default: rd_hit = 1'b0;
    endcase
  end

  // register file requests come from held command fields
  logic wr_en;
  logic [W-1:0] wr_val;
  assign gif.re = (st_q.fsm == iss_pkg::ISS_RD);
  assign gif.rset = st_q.current_shadow_set[SW-1:0];
  assign gif.ra = st_q.rs;
  assign gif.rb = st_q.rt;
  assign gif.we = wr_en;
  assign gif.wset = st_q.current_shadow_set[SW-1:0];
  assign gif.wa = st_q.rd;
  assign gif.wd = wr_val;

  logic swap;
  logic lsbe;
  logic acc;
  logic stall;
  logic pc_set;
  logic [31:0] step;
  logic [31:0] nxt_pc;
  logic [31:0] link;
  logic [1:0] lane;
  logic [W-1:0] a;
  logic [W-1:0] b;

  always_comb begin
    st_d = st_q;
    wr_en = 1'b0;
    wr_val = '0;
    pc_set = 1'b0;
    a = gif.qa;
    b = gif.qb;
    lane = 2'h0;
    // 16-bit steps only exist in the compressed encoding
    step = (st_q.isa_sel && st_q.is16) ? `ISS_STEP16 : `ISS_STEP32;
    nxt_pc = st_q.pc + step;
    link = st_q.pc + (step << 1);
    swap = st_q.flip_bit & st_q.user_mode;
    lsbe = st_q.mem_be ^ swap;
    st_d.swap_o = swap;
    st_d.lsbe_o = lsbe;
    st_d.fcc_o = RELEASE6 ? 1'b0 : st_q.coc1;
    st_d.strap_s1 = byte_order_strap;
    st_d.strap_s2 = st_q.strap_s1;

    // bus: answer one cycle into the access phase, commit on the next edge
    acc = psel & penable;
    stall = 1'b0;
    if (acc && !st_q.pready) begin
      // a new command waits until the previous one retires
      stall = pwrite && paddr == `ISS_OFF_CMD &&
              st_q.fsm != iss_pkg::ISS_IDLE;
      if (!stall) begin
        st_d.pready = 1'b1;
        st_d.pslverr = !rd_hit;
        st_d.prdata = pwrite ? 32'h0000_0000 : rd_val;
      end
    end else begin
      st_d.pready = 1'b0;
      st_d.pslverr = 1'b0;
    end
    if (acc && st_q.pready && pwrite && !st_q.pslverr) begin
      case (paddr)
        `ISS_OFF_CTRL: begin
          st_d.isa_sel = pwdata[`ISS_CTRL_ISA];
          st_d.user_mode = pwdata[`ISS_CTRL_USER];
          st_d.flip_bit = pwdata[`ISS_CTRL_FLIP];
          st_d.coc1 = pwdata[`ISS_CTRL_COC];
          st_d.current_shadow_set = pwdata[`ISS_CTRL_CSS +: 4];
        end
        `ISS_OFF_OPA: st_d.opa = pwdata;
        `ISS_OFF_OPB: st_d.opb = pwdata;
        `ISS_OFF_CMD: begin
          st_d.op = iss_pkg::iss_op_t'(pwdata[`ISS_CMD_OP +: 5]);
          st_d.rd = pwdata[`ISS_CMD_RD +: 5];
          st_d.rs = pwdata[`ISS_CMD_RS +: 5];
          st_d.rt = pwdata[`ISS_CMD_RT +: 5];
          st_d.is16 = pwdata[`ISS_CMD_IS16];
          st_d.fsm = iss_pkg::ISS_RD;
        end
        default: ;
      endcase
    end

    // one instruction time per command; effects land in the EX cycle
    case (st_q.fsm)
      iss_pkg::ISS_IDLE: ;
      iss_pkg::ISS_RD: st_d.fsm = iss_pkg::ISS_EX;
      iss_pkg::ISS_EX: begin
        st_d.fsm = iss_pkg::ISS_IDLE;
        st_d.br_pend = 1'b0;
        case (st_q.op)
          iss_pkg::ISS_NOP: ;
          iss_pkg::ISS_SETR: begin
            wr_val = sext(st_q.opa);
            wr_en = 1'b1;
          end
          iss_pkg::ISS_GETR: wr_val = a;
          iss_pkg::ISS_ADD: begin
            wr_val = a + b;
            wr_en = 1'b1;
          end
          iss_pkg::ISS_SUB: begin
            wr_val = a - b;
            wr_en = 1'b1;
          end
          iss_pkg::ISS_SLT: begin
            wr_val = W'($signed(a) < $signed(b));
            wr_en = 1'b1;
          end
          iss_pkg::ISS_SLL: begin
            wr_val = a << b[SHW-1:0];
            wr_en = 1'b1;
          end
          iss_pkg::ISS_SRL: begin
            wr_val = a >> b[SHW-1:0];
            wr_en = 1'b1;
          end
          iss_pkg::ISS_MUL: begin
            wr_val = W'($signed(a) * $signed(b));
            wr_en = 1'b1;
          end
          iss_pkg::ISS_DIV: begin
            // divide by zero gives zero rather than a trap
            wr_val = (b == '0) ? '0 : W'($signed(a) / $signed(b));
            wr_en = 1'b1;
          end
          iss_pkg::ISS_MOD: begin
            wr_val = (b == '0) ? '0 : W'($signed(a) % $signed(b));
            wr_en = 1'b1;
          end
          iss_pkg::ISS_EXT: begin
            wr_val = field_sel(a, st_q.opb[12:8], st_q.opb[4:0]);
            wr_en = 1'b1;
          end
          iss_pkg::ISS_LDB: begin
            // big-endian picks the mirrored lane of the word
            lane = lsbe ? ~st_q.opa[1:0] : st_q.opa[1:0];
            wr_val = W'(byte_of(st_q.opb, lane));
            wr_en = 1'b1;
          end
          iss_pkg::ISS_LL: begin
            st_d.ll_flag = 1'b1;
            st_d.ll_addr = st_q.opa;
          end
          iss_pkg::ISS_SC: begin
            wr_val = W'(st_q.ll_flag && st_q.ll_addr == st_q.opa);
            wr_en = 1'b1;
            st_d.ll_flag = 1'b0;
          end
          iss_pkg::ISS_ST: begin
            // word granularity: any store into the reserved word breaks it
            if (st_q.ll_addr[31:2] == st_q.opa[31:2]) begin
              st_d.ll_flag = 1'b0;
            end
          end
          iss_pkg::ISS_BR: begin
            st_d.br_pend = !st_q.br_pend;
            st_d.br_tgt = st_q.opa;
          end
          iss_pkg::ISS_BAL: begin
            st_d.br_pend = !st_q.br_pend;
            st_d.br_tgt = st_q.opa;
            // restart past the delay slot, low bit carries the isa select
            wr_val = sext({link[31:1], st_q.isa_sel});
            wr_en = 1'b1;
          end
          iss_pkg::ISS_EXC: begin
            st_d.epc = st_q.pc;
            nxt_pc = EXC_VECTOR;
            pc_set = 1'b1;
          end
          iss_pkg::ISS_ERET: begin
            nxt_pc = st_q.epc;
            pc_set = 1'b1;
            st_d.ll_flag = 1'b0;
          end
          iss_pkg::ISS_ADDPC: begin
            wr_val = sext(st_q.pc + st_q.opa);
            wr_en = 1'b1;
          end
          default: ;
        endcase
        // the slot instruction's own time carries the branch target
        if (!pc_set && st_q.br_pend) begin
          nxt_pc = st_q.br_tgt;
        end
        st_d.pc = nxt_pc;
        st_d.result = wr_val[31:0];
      end
      default: st_d.fsm = iss_pkg::ISS_IDLE;
    endcase

    if (rst) begin
      st_d = '0;
      st_d.strap_s1 = byte_order_strap;
      st_d.strap_s2 = st_q.strap_s1;
      // strap keeps tracking while reset is held, frozen at release
      st_d.mem_be = st_q.strap_s2;
      st_d.pc = PC_RESET;
      st_d.fsm = iss_pkg::ISS_IDLE;
      st_d.op = iss_pkg::ISS_NOP;
    end
  end

  always_ff @(posedge sys_clk) begin
    st_q <= st_d;
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign memory_byte_order_cfg = st_q.mem_be;
  assign loadstore_byte_order = st_q.lsbe_o;
  assign user_byte_swap_signal = st_q.swap_o;
  assign link_reservation_flag = st_q.ll_flag;
  assign instruction_set_select = st_q.isa_sel;
  assign fp_condition_code0 = st_q.fcc_o;
endmodule // iss_state_core
`default_nettype wire

// File: verification/iss_state_props.sv
// concurrent property checker for the architectural state block
`timescale 1ns/100ps
`default_nettype none
`include "iss_cfg.svh"
module iss_state_props (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ISS_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic memory_byte_order_cfg,
  input wire logic loadstore_byte_order,
  input wire logic user_byte_swap_signal,
  input wire logic link_reservation_flag,
  input wire logic instruction_set_select,
  input wire logic fp_condition_code0
);
  logic done_w;
  logic ctrl_w;
  logic swap_w;
  logic cmd_w;
  logic ll_w;
  assign done_w = psel && penable && pready && pwrite;
  assign ctrl_w = done_w && paddr == `ISS_OFF_CTRL;
  assign swap_w = ctrl_w && pwdata[2] && pwdata[1];
  assign cmd_w = done_w && paddr == `ISS_OFF_CMD;
  assign ll_w = cmd_w && pwdata[4:0] == 5'h0D;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse)
    else $error("ready held longer than one cycle");
  property p_unmapped;
    psel && penable && pready && paddr > 8'h18 |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access without error");
  property p_mapped;
    pready && paddr <= 8'h18 && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  a_mapped: assert property (p_mapped)
    else $error("mapped access flagged as error");
  property p_mem_held;
    !$past(rst) |-> $stable(memory_byte_order_cfg);
  endproperty
  a_mem_held: assert property (p_mem_held)
    else $error("memory byte order moved outside reset");
  property p_ldst_xor;
    !$past(rst) && !$past(rst, 2) |->
      loadstore_byte_order == (memory_byte_order_cfg ^ user_byte_swap_signal);
  endproperty
  a_ldst_xor: assert property (p_ldst_xor)
    else $error("load store order not memory order xor swap");
  property p_swap_cause;
    $rose(user_byte_swap_signal) |-> $past(swap_w) || $past(swap_w, 2);
  endproperty
  a_swap_cause: assert property (p_swap_cause)
    else $error("swap raised without flip and user mode");
  property p_isa_cause;
    $changed(instruction_set_select) |-> $past(ctrl_w) || $past(ctrl_w, 2);
  endproperty
  a_isa_cause: assert property (p_isa_cause)
    else $error("isa select moved without control write");
  property p_fcc_cause;
    $changed(fp_condition_code0) |-> $past(ctrl_w) || $past(ctrl_w, 2);
  endproperty
  a_fcc_cause: assert property (p_fcc_cause)
    else $error("condition code moved without control write");
  property p_ll_set;
    $rose(link_reservation_flag) |-> $past(ll_w, 3);
  endproperty
  a_ll_set: assert property (p_ll_set)
    else $error("reservation set without linked load");
  property p_ll_clear;
    $fell(link_reservation_flag) |-> $past(cmd_w, 3);
  endproperty
  a_ll_clear: assert property (p_ll_clear)
    else $error("reservation cleared without command");
  c_unmapped: cover property (pready && pslverr);
  c_ll: cover property ($rose(link_reservation_flag));
  c_swap: cover property ($rose(user_byte_swap_signal));
endmodule // iss_state_props
bind iss_state_core iss_state_props iss_state_props_i (.sys_clk, .rst,
  .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .memory_byte_order_cfg, .loadstore_byte_order, .user_byte_swap_signal,
  .link_reservation_flag, .instruction_set_select, .fp_condition_code0);
`default_nettype wire

// File: verification/isa_state_semantics_bench.sv
// self-checking bench for the architectural state block
`timescale 1ns/100ps
`default_nettype none
`include "iss_cfg.svh"
module isa_state_semantics_bench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic strap = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, mcfg, lsbo, swap, llf, isa, fcc, s;
  logic [32:0] exp_q[$];
  logic [31:0] a, b;
  int miscompares = 0;
  int total_checks = 0;
  int seed = 30456;
  always #20 sys_clk = ~sys_clk;
  iss_state_core iss_state_core_i (.sys_clk, .rst, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .byte_order_strap(strap), .memory_byte_order_cfg(mcfg),
    .loadstore_byte_order(lsbo), .user_byte_swap_signal(swap),
    .link_reservation_flag(llf), .instruction_set_select(isa),
    .fp_condition_code0(fcc));
  task end_sim;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task check(input logic [32:0] seen, input logic [32:0] want);
    total_checks++;
    if (seen !== want) begin
      miscompares++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask
  // pins looked at mid-cycle: an edge's own update is not visible at it
  // order: fcc, isa select, reservation, swap, ld/st order, memory order
  task pins(input logic [5:0] w);
    @(negedge sys_clk);
    check({27'h0, fcc, isa, llf, swap, lsbo, mcfg}, {27'h0, w});
    @(posedge sys_clk);
  endtask
  // request held until pready is sampled, then one released cycle
  task xfer(input logic wr, input logic [7:0] ad, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) begin
      miscompares++;
      end_sim;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task rd(input logic [7:0] ad, input logic [32:0] w);
    exp_q.push_back(w);
    xfer(1'b0, ad, 32'h0);
  endtask
  task st(input logic [6:0] w);
    rd(`ISS_OFF_STAT, {26'h0, w});
  endtask
  task res(input logic [31:0] w);
    rd(`ISS_OFF_RES, {1'b0, w});
  endtask
  // extra idle edge: result lands two cycles after the command commits
  task cmd(input logic [4:0] op, rd_, rs, rt, input logic h,
           input logic [31:0] x, y);
    xfer(1'b1, `ISS_OFF_OPA, x);
    xfer(1'b1, `ISS_OFF_OPB, y);
    xfer(1'b1, `ISS_OFF_CMD, {h, 2'h0, rt, 3'h0, rs, 3'h0, rd_, 3'h0, op});
    @(posedge sys_clk);
  endtask
  function automatic logic [31:0] alu(input logic [4:0] op,
                                      input logic [31:0] x, y);
    case (op)
      5'h03: alu = x + y;
      5'h04: alu = x - y;
      5'h05: alu = {31'h0, $signed(x) < $signed(y)};
      5'h06: alu = x << y[4:0];
      5'h07: alu = x >> y[4:0];
      5'h08: alu = x * y;
      5'h09: if (y == 0) alu = 32'h0; else alu = $signed(x) / $signed(y);
      default: if (y == 0) alu = 32'h0; else alu = $signed(x) % $signed(y);
    endcase
  endfunction
  always @(posedge sys_clk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      check({pslverr, prdata}, exp_q.pop_front());
    end
  end
  initial begin
    s = 1'($random(seed));
    strap <= s;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    st({5'h00, s, s});
    xfer(1'b1, `ISS_OFF_CTRL, 32'h0000_000E);
    st({5'h11, ~s, s});
    pins({4'b1001, ~s, s});
    xfer(1'b1, `ISS_OFF_CTRL, 32'h0000_0004);
    st({5'h00, s, s});
    rd(8'h40, {1'b1, 32'h0});
    a = $random(seed);
    b = $random(seed);
    cmd(5'h01, 5'h00, 5'h00, 5'h00, 1'b0, a, b);
    cmd(5'h02, 5'h00, 5'h00, 5'h00, 1'b0, a, b);
    res(32'h0);
    cmd(5'h01, 5'h05, 5'h00, 5'h00, 1'b0, a, b);
    xfer(1'b1, `ISS_OFF_CTRL, 32'h0000_0010);
    cmd(5'h01, 5'h05, 5'h00, 5'h00, 1'b0, b, a);
    cmd(5'h02, 5'h00, 5'h05, 5'h00, 1'b0, a, b);
    res(b);
    xfer(1'b1, `ISS_OFF_CTRL, 32'h0);
    cmd(5'h02, 5'h00, 5'h05, 5'h00, 1'b0, a, b);
    res(a);
    repeat (3) begin
      a = $random(seed);
      b = $random(seed);
      cmd(5'h01, 5'h01, 5'h00, 5'h00, 1'b0, a, b);
      cmd(5'h01, 5'h02, 5'h00, 5'h00, 1'b0, b, a);
      for (int k = 3; k <= 10; k++) begin
        cmd(5'(k), 5'h03, 5'h01, 5'h02, 1'b0, a, b);
        res(alu(5'(k), a, b));
      end
      cmd(5'h0B, 5'h03, 5'h01, 5'h00, 1'b0, a, 32'h0000_0704);
      res({28'h0, a[7:4]});
      cmd(5'h0B, 5'h03, 5'h01, 5'h00, 1'b0, a, 32'h0000_0309);
      res(32'h0);
      for (int k = 0; k < 4; k++) begin
        cmd(5'h0C, 5'h03, 5'h00, 5'h00, 1'b0, 32'(k), a);
        res({24'h0, a[8 * (k ^ {2{s}}) +: 8]});
      end
    end
    cmd(5'h0D, 5'h00, 5'h00, 5'h00, 1'b0, 32'h0000_0040, b);
    pins({4'b0010, s, s});
    cmd(5'h0E, 5'h03, 5'h00, 5'h00, 1'b0, 32'h0000_0040, b);
    res(32'h1);
    cmd(5'h0E, 5'h03, 5'h00, 5'h00, 1'b0, 32'h0000_0040, b);
    res(32'h0);
    // a plain store into the reserved word breaks the reservation
    cmd(5'h0D, 5'h00, 5'h00, 5'h00, 1'b0, 32'h0000_0040, b);
    cmd(5'h0F, 5'h00, 5'h00, 5'h00, 1'b0, 32'h0000_0042, b);
    cmd(5'h0E, 5'h03, 5'h00, 5'h00, 1'b0, 32'h0000_0040, b);
    res(32'h0);
    cmd(5'h0D, 5'h00, 5'h00, 5'h00, 1'b0, 32'h0000_0080, b);
    cmd(5'h13, 5'h00, 5'h00, 5'h00, 1'b0, a, b);
    pins({4'b0000, s, s});
    cmd(5'h12, 5'h00, 5'h00, 5'h00, 1'b0, a, b);
    cmd(5'h14, 5'h01, 5'h00, 5'h00, 1'b0, 32'h0, b);
    res(32'h0000_2000);
    cmd(5'h14, 5'h01, 5'h00, 5'h00, 1'b0, 32'h0000_0010, b);
    res(32'h0000_2014);
    cmd(5'h11, 5'h03, 5'h00, 5'h00, 1'b0, 32'h0000_3000, b);
    res(32'h0000_2010);
    cmd(5'h14, 5'h01, 5'h00, 5'h00, 1'b0, 32'h0, b);
    res(32'h0000_200C);
    cmd(5'h14, 5'h01, 5'h00, 5'h00, 1'b0, 32'h0, b);
    res(32'h0000_3000);
    cmd(5'h12, 5'h00, 5'h00, 5'h00, 1'b0, a, b);
    rd(`ISS_OFF_EPC, {1'b0, 32'h0000_3004});
    xfer(1'b1, `ISS_OFF_CTRL, 32'h0000_0001);
    pins({4'b0100, s, s});
    cmd(5'h14, 5'h01, 5'h00, 5'h00, 1'b1, 32'h0, b);
    res(32'h0000_2000);
    cmd(5'h14, 5'h01, 5'h00, 5'h00, 1'b0, 32'h0, b);
    res(32'h0000_2002);
    // plain delayed branch after a no-op, pc at 0x2006 here
    cmd(5'h00, 5'h00, 5'h00, 5'h00, 1'b0, 32'h0, b);
    cmd(5'h10, 5'h00, 5'h00, 5'h00, 1'b0, 32'h0000_4000, b);
    st({5'h04, s, s});
    cmd(5'h14, 5'h01, 5'h00, 5'h00, 1'b0, 32'h0, b);
    res(32'h0000_200E);
    cmd(5'h14, 5'h01, 5'h00, 5'h00, 1'b0, 32'h0, b);
    res(32'h0000_4000);
    end_sim;
  end
endmodule // isa_state_semantics_bench
`default_nettype wire
